// ===== src/sarc_pkg.sv
/*
 * Constants and carrier types for the successive-approximation converter control.
 * Assumes a 250 MHz system clock and a host-driven serial clock as the link domain.
 */
package sarc_pkg;
   localparam int ResultWidth = 18;
   localparam logic [17:0] AbortCode = 18'h3_FC00;
   localparam logic [17:0] ResultReset = 18'h0_0000;
   localparam logic [17:0] SignFlip = 18'h2_0000;
   localparam int ClkPeriodNs = 4;
   // Internal conversion time and nap recovery, in ns
   localparam int ConvTimeNs = 1160;
   localparam int NapRecoverNs = 200;
   localparam int ConvCycles = ConvTimeNs / ClkPeriodNs;
   localparam int NapCycles = (NapRecoverNs + ClkPeriodNs - 1) / ClkPeriodNs;
   localparam int CntWidth = 9;
   localparam logic [8:0] CntZero = 9'h000;
   localparam logic [4:0] BitIdxMsb = 5'h11;

   typedef enum logic [4:0] {
      SARC_SAMPLE = 5'b0_0001,
      SARC_CONVERT = 5'b0_0010,
      SARC_WAIT = 5'b0_0100,
      SARC_NAP = 5'b0_1000,
      SARC_DOWN = 5'b1_0000
   } sarc_state_t;

   // Host-side control pins, all asynchronous to clk
   typedef struct packed {
      logic convertStartN;
      logic chipSelectN;
      logic frameSync;
      logic powerDownIn;
      logic outputFormatSelect;
   } sarc_pins_t;
endpackage : sarc_pkg

// ===== src/sarc_serial_out.sv
/*
 * Serial clock edge marker running in the host serial clock domain.
 * Assumes reset is released while the serial clock stands still, as the host keeps it.
 */
`timescale 1ns/10ps
module sarc_serial_out (
   input wire logic sclk, // Host serial clock
   input wire logic rst, // Reset, active high, applied while sclk is still
   output logic edgeToggle // Flips on every serial clock rising edge
);
   logic edgeTog_reg;
   logic edgeTog_next;

   // Each rising edge flips the marker; the clk side counts the flips
   always_comb begin
      edgeTog_next = ~edgeTog_reg;
   end

   // Reset needs no serial clock edge, since the host holds the clock idle
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         edgeTog_reg <= 1'b0;
      end else begin
         edgeTog_reg <= edgeTog_next;
      end
   end

   assign edgeToggle = edgeTog_reg;
endmodule : sarc_serial_out

// ===== src/sarc_ctrl.sv
/*
 * Conversion sequencer, busy flag and serial data output control.
 * Assumes all host pins are asynchronous; serial clock is a second clock domain.
 */
`timescale 1ns/10ps
module sarc_ctrl (
   input wire logic clk, // 250 MHz internal conversion clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic sclk, // Host serial clock
   input wire sarc_pkg::sarc_pins_t pins, // Host control pins
   input wire logic [17:0] sampleValue, // Converted value from the analog core
   output logic busy, // High while converting
   output logic napActive, // Low-power nap indication
   output logic sdo, // Serial data out
   output logic sdoOe // Serial data output enable
);
   // Two-flop synchronisers for all pins
   sarc_pkg::sarc_pins_t pinMeta_reg;
   sarc_pkg::sarc_pins_t pinSync_reg;
   always_ff @(posedge clk) begin
      pinMeta_reg <= pins;
      pinSync_reg <= pinMeta_reg;
   end

   logic csN;
   logic fsQual;
   assign csN = pinSync_reg.chipSelectN;
   assign fsQual = pinSync_reg.frameSync & ~csN;

   // Qualified convert latch and edge state
   logic qualConvN_reg;
   logic qualConvN_next;
   logic qualPrev_reg;
   logic csPrev_reg;
   logic fsPrev_reg;
   logic convFall;
   logic csFall;
   logic fsRise;

   always_comb begin
      qualConvN_next = qualConvN_reg;
      if (!csN) begin
         qualConvN_next = pinSync_reg.convertStartN;
      end
      if (pinSync_reg.powerDownIn) begin
         qualConvN_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         qualConvN_reg <= 1'b1;
         qualPrev_reg <= 1'b1;
         csPrev_reg <= 1'b1;
         fsPrev_reg <= 1'b0;
      end else begin
         qualConvN_reg <= qualConvN_next;
         qualPrev_reg <= qualConvN_reg;
         csPrev_reg <= csN;
         fsPrev_reg <= fsQual;
      end
   end

   assign convFall = qualPrev_reg & ~qualConvN_reg;
   assign csFall = csPrev_reg & ~csN;
   assign fsRise = ~fsPrev_reg & fsQual;

   // Sequencer state
   sarc_pkg::sarc_state_t state_reg;
   sarc_pkg::sarc_state_t state_next;
   logic [8:0] cnt_reg;
   logic [8:0] cnt_next;
   logic [17:0] result_reg;
   logic [17:0] result_next;
   logic [17:0] held_reg;
   logic [17:0] held_next;
   logic busy_reg;
   logic busy_next;
   logic nap_reg;
   logic nap_next;
   logic convDone;
   logic sampleGo;
   logic busyFall;

   assign sampleGo = qualConvN_reg & ~csN;
   assign convDone = (state_reg == sarc_pkg::SARC_CONVERT) && (cnt_reg == sarc_pkg::CntZero);

   // Next state and result update
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      result_next = result_reg;
      held_next = held_reg;
      busyFall = 1'b0;
      if (cnt_reg != sarc_pkg::CntZero) begin
         cnt_next = cnt_reg - 9'h001;
      end
      unique case (state_reg)
         sarc_pkg::SARC_SAMPLE: begin
            if (convFall && cnt_reg == sarc_pkg::CntZero) begin
               state_next = sarc_pkg::SARC_CONVERT;
               held_next = sampleValue;
               cnt_next = 9'(sarc_pkg::ConvCycles - 1);
            end
         end
         sarc_pkg::SARC_CONVERT: begin
            if (convFall) begin
               state_next = sarc_pkg::SARC_WAIT;
               result_next = sarc_pkg::AbortCode;
               busyFall = 1'b1;
            end else if (convDone) begin
               result_next = held_reg;
               busyFall = 1'b1;
               if (!qualConvN_reg) begin
                  state_next = sarc_pkg::SARC_NAP;
               end else if (sampleGo) begin
                  state_next = sarc_pkg::SARC_SAMPLE;
               end else begin
                  state_next = sarc_pkg::SARC_WAIT;
               end
            end
         end
         sarc_pkg::SARC_WAIT: begin
            if (sampleGo) begin
               state_next = sarc_pkg::SARC_SAMPLE;
            end
         end
         sarc_pkg::SARC_NAP: begin
            if (sampleGo) begin
               state_next = sarc_pkg::SARC_SAMPLE;
               cnt_next = 9'(sarc_pkg::NapCycles);
            end
         end
         sarc_pkg::SARC_DOWN: begin
            state_next = sarc_pkg::SARC_WAIT;
         end
         default: begin
            state_next = sarc_pkg::SARC_WAIT;
         end
      endcase
      if (pinSync_reg.powerDownIn) begin
         state_next = sarc_pkg::SARC_DOWN;
         cnt_next = sarc_pkg::CntZero;
         result_next = sarc_pkg::ResultReset;
      end
      busy_next = (state_next == sarc_pkg::SARC_CONVERT);
      nap_next = (state_next == sarc_pkg::SARC_NAP);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= sarc_pkg::SARC_WAIT;
         cnt_reg <= sarc_pkg::CntZero;
         result_reg <= sarc_pkg::ResultReset;
         held_reg <= sarc_pkg::ResultReset;
         busy_reg <= 1'b0;
         nap_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         result_reg <= result_next;
         held_reg <= held_next;
         busy_reg <= busy_next;
         nap_reg <= nap_next;
      end
   end

   // Readout side: frame start and formatted word
   logic [17:0] word_reg;
   logic [17:0] word_next;
   logic frameStart;

   assign frameStart = (csFall & pinSync_reg.frameSync) | fsRise
      | (busyFall & fsQual);

   // Latch the formatted word at every frame start
   always_comb begin
      word_next = word_reg;
      if (frameStart) begin
         word_next = pinSync_reg.outputFormatSelect ?
            (result_next ^ sarc_pkg::SignFlip) : result_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         word_reg <= sarc_pkg::ResultReset;
      end else begin
         word_reg <= word_next;
      end
   end

   // Serial clock edge marker from the link domain; the word never crosses
   logic edgeTog;
   sarc_serial_out uShift (
      .sclk(sclk),
      .rst(rst),
      .edgeToggle(edgeTog)
   );

   // Marker crosses on two flops; each change is one serial clock rise
   logic edgeMeta_reg;
   logic edgeSync_reg;
   logic edgePrev_reg;
   logic sclkRise;
   logic [4:0] bitIdx_reg;
   logic [4:0] bitIdx_next;
   logic sdo_reg;
   logic sdo_next;
   logic sdoOe_reg;
   logic sdoOe_next;

   assign sclkRise = (edgeSync_reg ^ edgePrev_reg) & ~csN;

   // Bit index walks the word MSB first; a frame start restarts it
   always_comb begin
      bitIdx_next = bitIdx_reg;
      if (frameStart) begin
         bitIdx_next = sarc_pkg::BitIdxMsb;
      end else if (sclkRise && bitIdx_reg != 5'h00) begin
         bitIdx_next = bitIdx_reg - 5'h01;
      end
      sdo_next = word_next[bitIdx_next];
      sdoOe_next = ~csN & ~pinSync_reg.powerDownIn;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         edgeMeta_reg <= 1'b0;
         edgeSync_reg <= 1'b0;
         edgePrev_reg <= 1'b0;
         bitIdx_reg <= sarc_pkg::BitIdxMsb;
         sdo_reg <= 1'b0;
         sdoOe_reg <= 1'b0;
      end else begin
         edgeMeta_reg <= edgeTog;
         edgeSync_reg <= edgeMeta_reg;
         edgePrev_reg <= edgeSync_reg;
         bitIdx_reg <= bitIdx_next;
         sdo_reg <= sdo_next;
         sdoOe_reg <= sdoOe_next;
      end
   end

   assign busy = busy_reg;
   assign napActive = nap_reg;
   assign sdo = sdo_reg;
   assign sdoOe = sdoOe_reg;

   // Checks
   sequence seqAbort;
      state_reg == sarc_pkg::SARC_CONVERT && convFall && !pinSync_reg.powerDownIn;
   endsequence

   AST_BUSY_STATE: assert property (@(posedge clk) disable iff (rst)
      busy_reg == (state_reg == sarc_pkg::SARC_CONVERT))
      else $error("busy does not match conversion state");
   AST_ABORT_WAIT: assert property (@(posedge clk) disable iff (rst)
      seqAbort |=> state_reg == sarc_pkg::SARC_WAIT && !busy_reg)
      else $error("abort did not end in wait");
   AST_ABORT_CODE: assert property (@(posedge clk) disable iff (rst)
      seqAbort |=> result_reg == sarc_pkg::AbortCode)
      else $error("abort code not loaded");
   AST_START_CONV: assert property (@(posedge clk) disable iff (rst)
      state_reg == sarc_pkg::SARC_SAMPLE && convFall && cnt_reg == sarc_pkg::CntZero
      && !pinSync_reg.powerDownIn |=> busy_reg)
      else $error("conversion not started");
   AST_POWER_DOWN: assert property (@(posedge clk) disable iff (rst)
      pinSync_reg.powerDownIn |=> state_reg == sarc_pkg::SARC_DOWN && !sdoOe_reg)
      else $error("power down not entered");
   AST_NAP: assert property (@(posedge clk) disable iff (rst)
      convDone && !convFall && !qualConvN_reg && !pinSync_reg.powerDownIn |=> nap_reg)
      else $error("nap not entered");
   AST_BACK2BACK: assert property (@(posedge clk) disable iff (rst)
      convDone && !convFall && sampleGo && !pinSync_reg.powerDownIn
      |=> state_reg == sarc_pkg::SARC_SAMPLE)
      else $error("back to back sampling missed");
   AST_UNSELECTED: assert property (@(posedge clk) disable iff (rst)
      csN && !pinSync_reg.powerDownIn |=> $stable(qualConvN_reg))
      else $error("convert latch moved while unselected");

   // Readout steps: a frame start, then qualified serial clock rises
   sequence seqFrameStart;
      frameStart && !pinSync_reg.powerDownIn;
   endsequence

   sequence seqShiftEdge;
      sclkRise && !frameStart && bitIdx_reg != 5'h00;
   endsequence

   AST_FRAME_MSB: assert property (@(posedge clk) disable iff (rst)
      seqFrameStart |=> bitIdx_reg == sarc_pkg::BitIdxMsb && sdo_reg == word_reg[17])
      else $error("frame start did not present the msb");
   AST_FORMAT: assert property (@(posedge clk) disable iff (rst)
      seqFrameStart |=> word_reg == ($past(result_next)
      ^ {$past(pinSync_reg.outputFormatSelect), 17'h0_0000}))
      else $error("word format does not follow the select pin");
   AST_SHIFT: assert property (@(posedge clk) disable iff (rst)
      seqShiftEdge |=> bitIdx_reg == $past(bitIdx_reg) - 5'h01
      && sdo_reg == word_reg[bitIdx_reg])
      else $error("serial bit did not advance");
   AST_SCLK_UNSELECTED: assert property (@(posedge clk) disable iff (rst)
      csN |=> $stable(bitIdx_reg))
      else $error("bit index moved while unselected");
   AST_WAIT_HOLD: assert property (@(posedge clk) disable iff (rst)
      state_reg == sarc_pkg::SARC_WAIT && !sampleGo && !pinSync_reg.powerDownIn
      |=> state_reg == sarc_pkg::SARC_WAIT)
      else $error("wait left without a sample start");
endmodule : sarc_ctrl

// ===== tb/sarc_host.sv
/* Host model: drives control pins and serial clock, captures words.
   Assumes one caller at a time and sdo settled 17 ns after a serial clock rise. */
`timescale 1ns/10ps
module sarc_host (
   input wire logic clk, // Pin timing clock
   input wire logic sdo, // Serial data from device
   output sarc_pkg::sarc_pins_t pins, // Control pins
   output logic sclk, // Serial clock, high and still when idle
   output logic [17:0] word // Last word captured
);
   event done;
   // Idle: deselected, sync high, powered up
   initial begin
      pins = 5'h1C;
      sclk = 1'b1;
      word = 18'h0_0000;
   end
   // Apply a pin set at a falling edge
   task automatic drive(input sarc_pkg::sarc_pins_t p);
      @(negedge clk);
      pins = p;
   endtask : drive
   // Frame start by chip select with sync high, or by a sync pulse
   task automatic start(input logic bySync);
      @(negedge clk);
      pins.chipSelectN = ~bySync;
      pins.frameSync = ~bySync;
      repeat (8) @(negedge clk);
      pins.chipSelectN = 1'b0;
      pins.frameSync = 1'b1;
      repeat (8) @(negedge clk);
      pins.frameSync = ~bySync;
      repeat (12) @(negedge clk);
   endtask : start
   // One 48 ns serial clock period, off the clk edges, then take the next bit
   task automatic shift;
      #7 sclk = 1'b0;
      #24 sclk = 1'b1;
      #17 word = {word[16:0], sdo};
   endtask : shift
   // Read one word; a restart after pre bits drops the partial frame
   task automatic readWord(input logic bySync, input int pre);
      if (pre > 0) begin
         start(bySync);
         repeat (pre) shift();
      end
      start(bySync);
      word = {17'h0_0000, sdo};
      repeat (17) shift();
      -> done;
   endtask : readWord
endmodule : sarc_host

// ===== tb/sarc_ctrl_tb.sv
/* Bench for the converter control: conversions, nap, abort, power-down, readout.
   Assumes the host model drives every pin and the serial clock. */
`timescale 1ns/10ps
module sarc_ctrl_tb;
   logic clk, rst, sclk, busy, napActive, sdo, sdoOe, fmt;
   logic [17:0] sampleValue, word, val, prev;
   logic [31:0] seed;
   logic [17:0] expQ[$];
   sarc_pkg::sarc_pins_t pins;
   int miscompares = 0;
   int comparisons = 0;
   int run = 0;
   int lastRun = 0;
   sarc_ctrl i_dut (.clk(clk), .rst(rst), .sclk(sclk), .pins(pins),
      .sampleValue(sampleValue), .busy(busy), .napActive(napActive), .sdo(sdo), .sdoOe(sdoOe));
   sarc_host i_host (.clk(clk), .sdo(sdo), .pins(pins), .sclk(sclk), .word(word));
   // System clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Length of the last busy pulse
   always @(posedge clk) begin
      if (busy === 1'b1) begin
         run <= run + 1;
      end else if (run != 0) begin
         lastRun <= run;
         run <= 0;
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input string name, input logic [17:0] e, input logic [17:0] g);
      comparisons++;
      if (e !== g) begin
         $display("[ERR] %s expected %h seen %h", name, e, g);
         miscompares++;
      end
   endtask : check
   task automatic wrap_up;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up
   // Bounded wait for a busy level
   task automatic waitBusy(input logic lvl, input int limit);
      int n;
      n = 0;
      while (busy !== lvl) begin
         @(negedge clk);
         n++;
         if (n > limit) begin
            $display("[ERR] busy wait expected %b seen timeout", lvl);
            miscompares++;
            wrap_up();
         end
      end
   endtask : waitBusy
   task automatic setp(input logic c, input logic s, input logic f, input logic p, input logic m);
      i_host.drive('{c, s, f, p, m});
   endtask : setp
   // Compare each captured word with the oldest note
   always @(i_host.done) begin
      if (expQ.size() == 0) begin
         comparisons++;
         $display("[ERR] serial word expected none seen %h", word);
         miscompares++;
      end else begin
         check("serial word", expQ.pop_front(), word);
      end
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      sampleValue = 18'h0_0000;
      seed = 32'hd6fd_c848;
      prev = sarc_pkg::ResultReset;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      check("busy reset", 18'h0_0000, 18'(busy));
      check("oe unselected", 18'h0_0000, 18'(sdoOe));
      setp(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      repeat (20) @(negedge clk);
      check("busy unselected", 18'h0_0000, 18'(busy));
      setp(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      repeat (20) @(negedge clk);
      check("oe selected", 18'h0_0001, 18'(sdoOe));
      // Nap end, back-to-back with read during conversion, format and restart
      for (int i = 0; i < 3; i++) begin
         fmt = (i == 2);
         val = seed[17:0];
         seed = lfsr(seed);
         setp(1'b1, 1'b0, i == 0, 1'b0, fmt);
         sampleValue = val;
         repeat (60) @(negedge clk);
         setp(1'b0, 1'b0, i == 0, 1'b0, fmt);
         waitBusy(1'b1, 10);
         if (i == 1) begin
            expQ.push_back(prev);
            i_host.readWord(1'b1, 0);
            setp(1'b1, 1'b0, 1'b0, 1'b0, fmt);
         end
         waitBusy(1'b0, 400);
         repeat (6) @(negedge clk);
         check("busy length", 18'(sarc_pkg::ConvCycles), 18'(lastRun));
         check("nap", 18'(i != 1), 18'(napActive));
         if (i == 0) begin
            check("msb at busy fall", 18'(val[17]), 18'(sdo));
         end
         expQ.push_back(fmt ? val ^ sarc_pkg::SignFlip : val);
         i_host.readWord(i != 0, (i == 2) ? 5 : 0);
         prev = val;
      end
      // Abort mid-conversion
      setp(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      repeat (60) @(negedge clk);
      setp(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      waitBusy(1'b1, 10);
      repeat (30) @(negedge clk);
      setp(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      repeat (10) @(negedge clk);
      setp(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      waitBusy(1'b0, 20);
      repeat (60) @(negedge clk);
      check("busy after abort", 18'h0_0000, 18'(busy));
      check("nap after abort", 18'h0_0000, 18'(napActive));
      expQ.push_back(sarc_pkg::AbortCode);
      i_host.readWord(1'b0, 0);
      // Power-down during a conversion
      setp(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      repeat (60) @(negedge clk);
      setp(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      waitBusy(1'b1, 10);
      setp(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      repeat (10) @(negedge clk);
      check("busy powered down", 18'h0_0000, 18'(busy));
      check("oe powered down", 18'h0_0000, 18'(sdoOe));
      check("words pending", 18'h0_0000, 18'(expQ.size()));
      wrap_up();
   end
endmodule : sarc_ctrl_tb
